// file: include/ldocps_pkg.sv
// Purpose: constants and types of the regulator control and page bank
// Assumes: 8-bit register addresses and data over an I2C slave port
// Notes:
// Function
// RL1: reg3 bit 7 picks off (0) or sleep (1) after a turn-off event.
// RL2: reg3 bit 6 set allows low-power entry; clear forbids it.
// RL3: reg3 bit 5 set switches the regulator off during standby.
// RL4: reg3 bit 4 turns the regulator on (1) or off (0).
// RL5: reg3 bits 3:0 hold the output-voltage code, forwarded out.
// RL6: reg4 bit 7 picks off (0) or sleep (1) after a turn-off event.
// RL7: reg4 bit 6 set allows low-power entry; clear forbids it.
// RL8: reg4 bit 5 set switches the regulator off during standby.
// RL9: reg4 bit 4 turns the regulator on (1) or off (0).
// RL10: reg4 bits 3:0 hold its output-voltage code.
// RL11: page low nibble 0 functional, 1 extended one, 2 extended two.
// RL12: 8-bit addresses and data; thirty-two pages, few reachable.
// RL13: 0x00-0x7F shared on every page; 0x80-0xFF page specific.
// RL14: host writes page 0x01 or 0x02 at 0x7F before extended access.
// RL15: functional range stays reachable whatever page is selected.
// RL16: unlisted addresses read 0x00 and ignore writes.
// RL17: write-1-to-clear bits clear on 1 and keep on 0.
// RL18: fuse-dependent bits load at start-up, then host writable.
// RL19: regulator control registers read and write at any time.
// RL20: each bit returns to default only on its own reset source.
// RL21: page codes above two unsupported; page upper bits read zero.
package ldocps_pkg;
   localparam logic [7:0] PAGE_ADDR   = 8'h7F;
   localparam logic [7:0] REG3_ADDR   = 8'h70;
   localparam logic [7:0] REG4_ADDR   = 8'h71;
   localparam logic [7:0] EXT_BASE    = 8'h80;
   localparam logic [7:0] RSVD_READ   = 8'h00;
   localparam logic [7:0] PTR_STEP    = 8'h01;
   localparam int         OMODE_BIT   = 7;
   localparam int         LPWR_BIT    = 6;
   localparam int         STBY_BIT    = 5;
   localparam int         EN_BIT      = 4;
   localparam int         VSEL_MSB    = 3;
   localparam logic [2:0] CTL_HI_RST  = 3'h0;
   localparam logic [3:0] PAGE_FUNC   = 4'h0;
   localparam logic [3:0] PAGE_EXT1   = 4'h1;
   localparam logic [3:0] PAGE_EXT2   = 4'h2;
   localparam logic [3:0] PAGE_RST    = 4'h0;
   localparam logic [3:0] PAGE_PAD    = 4'h0;
   localparam int         PAGE_COUNT  = 32;
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam logic [3:0] CNT_STEP    = 4'h1;
   localparam logic [6:0] DEV_ADDR_DEF = 7'h08;

   typedef enum logic [3:0] {
      LDOCPS_IDLE  = 4'b0000,
      LDOCPS_ADDR  = 4'b0001,
      LDOCPS_REG   = 4'b0010,
      LDOCPS_WDATA = 4'b0011,
      LDOCPS_ACK   = 4'b0100,
      LDOCPS_RDATA = 4'b0101,
      LDOCPS_RACK  = 4'b0110
   } ldocps_i2c_t;

   typedef enum logic [1:0] {
      LDOCPS_OFF   = 2'b00,
      LDOCPS_ON    = 2'b01,
      LDOCPS_LOWPW = 2'b10,
      LDOCPS_SLEEP = 2'b11
   } ldocps_mode_t;
endpackage

// file: rtl/ldocps_top.sv
// Purpose: third/fourth regulator control registers and page select
// Assumes: host is an I2C master; pins are asynchronous to clk
// Notes: extended pages hold no registers in this block
`timescale 1ns/1ns
module ldocps_top
   import ldocps_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   // i2c pins, open drain
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // device pins
   input  wire logic       power_button_input,
   input  wire logic       digital_reset_input_n,
   // device state, same clock
   input  wire logic       standby_active,
   input  wire logic       low_power_request,
   // fuse defaults
   input  wire logic       fuse_reg3_on,
   input  wire logic [3:0] fuse_reg3_voltage_code,
   input  wire logic       fuse_reg4_on,
   input  wire logic [3:0] fuse_reg4_voltage_code,
   // third regulator
   output logic            reg3_turnoff_sleep_select,
   output logic            reg3_low_power_allow,
   output logic            reg3_standby_off,
   output logic            reg3_on,
   output logic [3:0]      reg3_voltage_code,
   output logic [1:0]      reg3_mode,
   // fourth regulator
   output logic            reg4_turnoff_sleep_select,
   output logic            reg4_low_power_allow,
   output logic            reg4_standby_off,
   output logic            reg4_on,
   output logic [3:0]      reg4_voltage_code,
   output logic [1:0]      reg4_mode,
   // page
   output logic [3:0]      active_page,
   output logic            page_supported
);

   logic              rst_s1;
   logic              rst_n;
   logic              drst_s1;
   logic              drst_s2;
   logic              pb_s1;
   logic              pb_s2;
   logic              pb_d;
   logic              scl_s1;
   logic              scl_s2;
   logic              scl_d;
   logic              sda_s1;
   logic              sda_s2;
   logic              sda_d;
   logic              load_r;
   logic              pwroff_r;
   logic              pwroff_nxt;
   logic              pb_evt;
   logic              start;
   logic              stop;
   logic              scl_rise;
   logic              scl_fall;
   ldocps_i2c_t       st_r;
   ldocps_i2c_t       nx_r;
   logic [3:0]        cnt_r;
   logic [7:0]        sh_r;
   logic [7:0]        ptr_r;
   logic              oe_r;
   logic              wr_stb_r;
   logic [7:0]        wr_addr_r;
   logic [7:0]        wr_data_r;
   logic [3:0]        page_r;
   logic              page_ok_r;
   logic [7:0]        ctl_r [2];
   ldocps_mode_t      mode_r [2];
   logic [4:0]        fuse_w [2];
   logic [7:0]        rd_data;

   // register read decode
   function automatic logic [7:0] rd_sel(
      input logic [7:0] addr,
      input logic [3:0] page,
      input logic [7:0] c3,
      input logic [7:0] c4
   );
      logic [7:0] v;
      v = RSVD_READ;
      if (addr >= EXT_BASE) begin
         v = RSVD_READ; // [RL13] [RL21] no extended regs on any page
      end else begin
         case (addr) // [RL15] functional decode ignores the page
            PAGE_ADDR: v = {PAGE_PAD, page}; // [RL21]
            REG3_ADDR: v = c3; // [RL19]
            REG4_ADDR: v = c4; // [RL19]
            default:   v = RSVD_READ; // [RL16]
         endcase
      end
      return v;
   endfunction

   // regulator state from its control byte
   function automatic ldocps_mode_t mode_of(
      input logic [7:0] c,
      input logic       off_evt,
      input logic       stby,
      input logic       lpreq
   );
      ldocps_mode_t m;
      m = LDOCPS_OFF;
      if (off_evt) begin
         m = c[OMODE_BIT] ? LDOCPS_SLEEP : LDOCPS_OFF; // [RL1] [RL6]
      end else if (!c[EN_BIT]) begin
         m = LDOCPS_OFF; // [RL4] [RL9]
      end else if (stby && c[STBY_BIT]) begin
         m = LDOCPS_OFF; // [RL3] [RL8]
      end else if (lpreq && c[LPWR_BIT]) begin
         m = LDOCPS_LOWPW; // [RL2] [RL7]
      end else begin
         m = LDOCPS_ON;
      end
      return m;
   endfunction

   // reset release, two stages
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else if (ce) begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // pin synchronisers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drst_s1 <= 1'b0;
         drst_s2 <= 1'b0;
         pb_s1   <= 1'b0;
         pb_s2   <= 1'b0;
         pb_d    <= 1'b0;
         scl_s1  <= 1'b1;
         scl_s2  <= 1'b1;
         scl_d   <= 1'b1;
         sda_s1  <= 1'b1;
         sda_s2  <= 1'b1;
         sda_d   <= 1'b1;
      end else if (ce) begin
         drst_s1 <= digital_reset_input_n;
         drst_s2 <= drst_s1;
         pb_s1   <= power_button_input;
         pb_s2   <= pb_s1;
         pb_d    <= pb_s2;
         scl_s1  <= scl_in;
         scl_s2  <= scl_s1;
         scl_d   <= scl_s2;
         sda_s1  <= sda_in;
         sda_s2  <= sda_s1;
         sda_d   <= sda_s2;
      end
   end

   assign pb_evt   = pb_s2 & ~pb_d;
   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign start    = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop     = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign rd_data  = rd_sel(ptr_r, page_r, ctl_r[0], ctl_r[1]);

   // serial engine; 8-bit pointer, auto-increment per byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= LDOCPS_IDLE;
         nx_r      <= LDOCPS_IDLE;
         cnt_r     <= 4'h0;
         sh_r      <= 8'h00;
         ptr_r     <= 8'h00;
         oe_r      <= 1'b0;
         wr_stb_r  <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
      end else if (ce) begin
         wr_stb_r <= 1'b0;
         if (!drst_s2) begin
            st_r <= LDOCPS_IDLE;
            oe_r <= 1'b0;
         end else if (start) begin
            st_r  <= LDOCPS_ADDR;
            cnt_r <= 4'h0;
            oe_r  <= 1'b0;
         end else if (stop) begin
            st_r <= LDOCPS_IDLE;
            oe_r <= 1'b0;
         end else begin
            case (st_r)
               LDOCPS_ADDR, LDOCPS_REG, LDOCPS_WDATA: begin
                  if (scl_rise) begin
                     sh_r  <= {sh_r[6:0], sda_s2};
                     cnt_r <= cnt_r + CNT_STEP;
                  end else if (scl_fall && cnt_r == BYTE_BITS) begin
                     cnt_r <= 4'h0;
                     if (st_r == LDOCPS_ADDR) begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                           oe_r <= 1'b1;
                           st_r <= LDOCPS_ACK;
                           nx_r <= sh_r[0] ? LDOCPS_RDATA : LDOCPS_REG;
                        end else begin
                           st_r <= LDOCPS_IDLE;
                        end
                     end else if (st_r == LDOCPS_REG) begin
                        ptr_r <= sh_r; // [RL12] 8-bit address
                        oe_r  <= 1'b1;
                        st_r  <= LDOCPS_ACK;
                        nx_r  <= LDOCPS_WDATA;
                     end else begin
                        wr_stb_r  <= 1'b1;
                        wr_addr_r <= ptr_r;
                        wr_data_r <= sh_r;
                        ptr_r     <= ptr_r + PTR_STEP;
                        oe_r      <= 1'b1;
                        st_r      <= LDOCPS_ACK;
                        nx_r      <= LDOCPS_WDATA;
                     end
                  end
               end
               LDOCPS_ACK: begin
                  if (scl_fall) begin
                     cnt_r <= 4'h0;
                     st_r  <= nx_r;
                     if (nx_r == LDOCPS_RDATA) begin
                        sh_r  <= rd_data;
                        ptr_r <= ptr_r + PTR_STEP;
                        oe_r  <= ~rd_data[7];
                     end else begin
                        oe_r <= 1'b0;
                     end
                  end
               end
               LDOCPS_RDATA: begin
                  if (scl_rise) begin
                     cnt_r <= cnt_r + CNT_STEP;
                  end else if (scl_fall) begin
                     if (cnt_r == BYTE_BITS) begin
                        oe_r  <= 1'b0;
                        cnt_r <= 4'h0;
                        st_r  <= LDOCPS_RACK;
                     end else begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        oe_r <= ~sh_r[6];
                     end
                  end
               end
               LDOCPS_RACK: begin
                  // nack ends the read; ack reuses the fall in ACK
                  if (scl_rise) begin
                     if (sda_s2) begin
                        st_r <= LDOCPS_IDLE;
                     end else begin
                        st_r <= LDOCPS_ACK;
                        nx_r <= LDOCPS_RDATA;
                     end
                  end
               end
               default: begin
                  st_r <= LDOCPS_IDLE;
               end
            endcase
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe  = oe_r;

   // page select, reset by the digital reset pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         page_r    <= PAGE_RST;
         page_ok_r <= 1'b1;
      end else if (ce) begin
         if (!drst_s2) begin
            page_r <= PAGE_RST; // [RL20]
         end else if (wr_stb_r && wr_addr_r == PAGE_ADDR) begin
            page_r <= wr_data_r[3:0]; // [RL11] [RL14]
         end
         page_ok_r <= (page_r == PAGE_FUNC) || (page_r == PAGE_EXT1) ||
                      (page_r == PAGE_EXT2); // [RL21]
      end
   end

   assign active_page    = page_r;
   assign page_supported = page_ok_r;

   // fuse load one cycle after release; no w1c bits live here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_r <= 1'b1;
      end else if (ce) begin
         load_r <= 1'b0;
      end
   end

   assign fuse_w[0] = {fuse_reg3_on, fuse_reg3_voltage_code};
   assign fuse_w[1] = {fuse_reg4_on, fuse_reg4_voltage_code};

   // control bytes, core power-on reset group
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 2; i++) begin
            ctl_r[i] <= 8'h00; // [RL20]
         end
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            if (load_r) begin
               ctl_r[i] <= {CTL_HI_RST, fuse_w[i]}; // [RL18]
            end else if (wr_stb_r &&
                         wr_addr_r == (i == 0 ? REG3_ADDR : REG4_ADDR)) begin
               ctl_r[i] <= wr_data_r; // [RL17] [RL19] plain read/write
            end
         end
      end
   end

   // turn-off latch: event wins over the digital reset clear
   assign pwroff_nxt = pb_evt | (pwroff_r & drst_s2);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwroff_r <= 1'b0;
      end else if (ce) begin
         pwroff_r <= pwroff_nxt;
      end
   end

   // regulator modes, registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r[0] <= LDOCPS_OFF;
         mode_r[1] <= LDOCPS_OFF;
      end else if (ce) begin
         for (int i = 0; i < 2; i++) begin
            mode_r[i] <= mode_of(ctl_r[i], pwroff_r, standby_active,
                                 low_power_request);
         end
      end
   end

   assign reg3_turnoff_sleep_select = ctl_r[0][OMODE_BIT]; // [RL1]
   assign reg3_low_power_allow      = ctl_r[0][LPWR_BIT]; // [RL2]
   assign reg3_standby_off          = ctl_r[0][STBY_BIT]; // [RL3]
   assign reg3_on                   = ctl_r[0][EN_BIT]; // [RL4]
   assign reg3_voltage_code         = ctl_r[0][VSEL_MSB:0]; // [RL5]
   assign reg3_mode                 = mode_r[0];
   assign reg4_turnoff_sleep_select = ctl_r[1][OMODE_BIT]; // [RL6]
   assign reg4_low_power_allow      = ctl_r[1][LPWR_BIT]; // [RL7]
   assign reg4_standby_off          = ctl_r[1][STBY_BIT]; // [RL8]
   assign reg4_on                   = ctl_r[1][EN_BIT]; // [RL9]
   assign reg4_voltage_code         = ctl_r[1][VSEL_MSB:0]; // [RL10]
   assign reg4_mode                 = mode_r[1];

   a_reserved_read: assert property ( // [RL16]
      @(posedge clk) disable iff (!rst_n)
      (ptr_r != PAGE_ADDR && ptr_r != REG3_ADDR && ptr_r != REG4_ADDR)
      |-> rd_data == RSVD_READ)
      else $error("reserved address read nonzero");

   a_ext_read_zero: assert property ( // [RL13]
      @(posedge clk) disable iff (!rst_n)
      ptr_r >= EXT_BASE |-> rd_data == RSVD_READ)
      else $error("extended read nonzero");

   a_page_upper: assert property ( // [RL21]
      @(posedge clk) disable iff (!rst_n)
      ptr_r == PAGE_ADDR |-> rd_data == {PAGE_PAD, page_r})
      else $error("page readback wrong");

   a_page_write: assert property ( // [RL11]
      @(posedge clk) disable iff (!rst_n)
      ce && drst_s2 && wr_stb_r && wr_addr_r == PAGE_ADDR
      |=> page_r == $past(wr_data_r[3:0]))
      else $error("page write lost");

   a_reg3_write: assert property ( // [RL19]
      @(posedge clk) disable iff (!rst_n)
      ce && !load_r && wr_stb_r && wr_addr_r == REG3_ADDR
      |=> ctl_r[0] == $past(wr_data_r) && $stable(ctl_r[1]))
      else $error("reg3 write wrong");

   a_rsvd_write: assert property ( // [RL16]
      @(posedge clk) disable iff (!rst_n)
      ce && !load_r && drst_s2 && wr_stb_r && wr_addr_r != PAGE_ADDR &&
      wr_addr_r != REG3_ADDR && wr_addr_r != REG4_ADDR
      |=> $stable(ctl_r[0]) && $stable(ctl_r[1]) && $stable(page_r))
      else $error("reserved write changed state");

   a_fuse_load: assert property ( // [RL18]
      @(posedge clk) disable iff (!rst_n)
      ce && load_r |=> ctl_r[1] == {CTL_HI_RST, $past(fuse_w[1])})
      else $error("fuse default not loaded");

   a_turnoff_mode: assert property ( // [RL1]
      @(posedge clk) disable iff (!rst_n)
      ce && pwroff_r |=> reg3_mode == ($past(ctl_r[0][OMODE_BIT]) ?
                                       LDOCPS_SLEEP : LDOCPS_OFF))
      else $error("turn-off mode wrong");

   a_standby_off: assert property ( // [RL8]
      @(posedge clk) disable iff (!rst_n)
      ce && !pwroff_r && standby_active && ctl_r[1][STBY_BIT]
      |=> reg4_mode == LDOCPS_OFF)
      else $error("standby did not switch off");

   a_low_power: assert property ( // [RL2]
      @(posedge clk) disable iff (!rst_n)
      ce && !pwroff_r && ctl_r[0][EN_BIT] && !standby_active &&
      low_power_request
      |=> (reg3_mode == LDOCPS_LOWPW) == $past(ctl_r[0][LPWR_BIT]))
      else $error("low-power gating wrong");

endmodule

// file: dv/ldocps_host_model.sv
// Purpose: behavioural I2C master standing in for the host processor
// Assumes: open-drain SDA with pull-up; wire level is worked out outside
// Notes: SCL is held high between frames, quarter bit is 8 clk
`timescale 1ns/1ns
module ldocps_host_model (
   // clock
   input  wire logic clk,
   // i2c wire
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_pull
);
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   // every change lands just after an edge, never twice in one step
   task automatic q_wait;
      repeat (8) @(posedge clk);
   endtask

   task automatic start;
      q_wait;
      sda_pull <= 1'b0;
      q_wait;
      scl <= 1'b1;
      q_wait;
      sda_pull <= 1'b1;
      q_wait;
      scl <= 1'b0;
   endtask

   task automatic stop;
      q_wait;
      sda_pull <= 1'b1;
      q_wait;
      scl <= 1'b1;
      q_wait;
      sda_pull <= 1'b0;
      q_wait;
   endtask

   // a one is sent by releasing, so the same task also reads a bit
   task automatic bit_io(input logic b, output logic s);
      q_wait;
      sda_pull <= !b;
      q_wait;
      scl <= 1'b1;
      q_wait;
      s = sda_wire;
      q_wait;
      scl <= 1'b0;
   endtask

   // 8-bit units, msb first
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = !s;
   endtask

   task automatic recv(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, s);
   endtask
endmodule

// file: dv/testbench.sv
// Purpose: self-checking bench of the regulator control and page bank
// Assumes: fuse defaults reg3 on, code A; reg4 off, code 5
// Notes: registers reached only over I2C through the host model
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   errors++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
   import ldocps_pkg::*;
   localparam logic [7:0] WR_ADDR = {DEV_ADDR_DEF, 1'b0};
   localparam logic [7:0] RD_ADDR = {DEV_ADDR_DEF, 1'b1};
   localparam int         LIMIT   = 90000;
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic       pwr_btn = 1'b0;
   logic       dig_rst_n = 1'b1;
   logic       stby = 1'b0;
   logic       lpreq = 1'b0;
   logic       scl;
   logic       pull;
   logic       sda_out;
   logic       sda_oe;
   wire  logic sda_wire = !(pull || (sda_oe && !sda_out));
   logic       r3_sl, r3_lp, r3_sb, r3_on, r4_sl, r4_lp, r4_sb, r4_on;
   logic [3:0] r3_v, r4_v, page;
   logic [1:0] r3_m, r4_m;
   logic       page_ok;
   int         errors = 0;
   int         checks_done = 0;
   int         cyc = 0;

   always #20 clk = ~clk;

   ldocps_top u_ldocps_top (
      .clk(clk), .resetn(resetn), .ce(1'b1),
      .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .power_button_input(pwr_btn), .digital_reset_input_n(dig_rst_n),
      .standby_active(stby), .low_power_request(lpreq),
      .fuse_reg3_on(1'b1), .fuse_reg3_voltage_code(4'hA),
      .fuse_reg4_on(1'b0), .fuse_reg4_voltage_code(4'h5),
      .reg3_turnoff_sleep_select(r3_sl), .reg3_low_power_allow(r3_lp),
      .reg3_standby_off(r3_sb), .reg3_on(r3_on), .reg3_voltage_code(r3_v),
      .reg3_mode(r3_m),
      .reg4_turnoff_sleep_select(r4_sl), .reg4_low_power_allow(r4_lp),
      .reg4_standby_off(r4_sb), .reg4_on(r4_on), .reg4_voltage_code(r4_v),
      .reg4_mode(r4_m), .active_page(page), .page_supported(page_ok));

   ldocps_host_model u_host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
      .sda_pull(pull));

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         errors++;
         end_of_test;
      end
   end

   task automatic tx(input logic [7:0] d);
      logic a;
      u_host.send(d, a);
      `CHK("ack", 1'b1, a)
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      u_host.start;
      tx(WR_ADDR);
      tx(p);
      tx(d);
      u_host.stop;
   endtask

   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      u_host.start;
      tx(WR_ADDR);
      tx(p);
      u_host.start;
      tx(RD_ADDR);
      u_host.recv(d, 1'b1);
      u_host.stop;
      `CHK("read", e, d)
   endtask

   task automatic t_reset;
      `CHK("r3 on", 1'b1, r3_on)
      `CHK("r3 code", 4'hA, r3_v)
      `CHK("r4 hi", 4'h0, {r4_sl, r4_lp, r4_sb, r4_on})
      `CHK("r4 code", 4'h5, r4_v)
      `CHK("page", 4'h0, page)
      `CHK("page ok", 1'b1, page_ok)
      `CHK("r3 mode", LDOCPS_ON, r3_m)
      `CHK("r4 mode", LDOCPS_OFF, r4_m)
      rd(REG3_ADDR, 8'h1A);
   endtask

   // two data bytes in one frame, then a two-byte read back
   task automatic t_burst;
      logic [7:0] d;
      u_host.start;
      tx(WR_ADDR);
      tx(REG3_ADDR);
      tx(8'hE9);
      tx(8'h36);
      u_host.stop;
      `CHK("r3 bits", 4'hE, {r3_sl, r3_lp, r3_sb, r3_on})
      `CHK("r3 code", 4'h9, r3_v)
      `CHK("r4 bits", 4'h3, {r4_sl, r4_lp, r4_sb, r4_on})
      `CHK("r4 code", 4'h6, r4_v)
      `CHK("r3 mode", LDOCPS_OFF, r3_m)
      `CHK("r4 mode", LDOCPS_ON, r4_m)
      u_host.start;
      tx(WR_ADDR);
      tx(REG3_ADDR);
      u_host.start;
      tx(RD_ADDR);
      u_host.recv(d, 1'b0);
      `CHK("rd r3", 8'hE9, d)
      u_host.recv(d, 1'b1);
      u_host.stop;
      `CHK("rd r4", 8'h36, d)
   endtask

   task automatic t_modes;
      wr(REG4_ADDR, 8'h70);
      wr(REG3_ADDR, 8'h90);
      @(posedge clk);
      stby <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("stby off", LDOCPS_OFF, r4_m)
      `CHK("stby keep", LDOCPS_ON, r3_m)
      stby <= 1'b0;
      lpreq <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK("low pw", LDOCPS_LOWPW, r4_m)
      `CHK("no lp", LDOCPS_ON, r3_m)
      lpreq <= 1'b0;
      pwr_btn <= 1'b1;
      repeat (10) @(posedge clk);
      `CHK("r3 sleep", LDOCPS_SLEEP, r3_m)
      `CHK("r4 off", LDOCPS_OFF, r4_m)
      pwr_btn <= 1'b0;
      wr(PAGE_ADDR, 8'h02);
      @(posedge clk);
      dig_rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      dig_rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      // digital reset clears page and latch but not the ctl bytes
      `CHK("page rst", 4'h0, page)
      `CHK("r3 back", LDOCPS_ON, r3_m)
      `CHK("r4 back", LDOCPS_ON, r4_m)
      rd(REG4_ADDR, 8'h70);
   endtask

   task automatic t_pages;
      logic a;
      for (int c = 0; c < 4; c++) begin
         wr(PAGE_ADDR, 8'(c));
         repeat (3) @(posedge clk);
         `CHK("page", 4'(c), page)
         `CHK("page ok", c < 3, page_ok)
      end
      wr(PAGE_ADDR, 8'hF2);
      rd(PAGE_ADDR, 8'h02);
      rd(REG3_ADDR, 8'h90);
      wr(8'h85, 8'hFF);
      rd(8'h85, RSVD_READ);
      wr(8'h6E, 8'hFF);
      rd(8'h6E, RSVD_READ);
      rd(REG3_ADDR, 8'h90);
      u_host.start;
      u_host.send(WR_ADDR ^ 8'h02, a);
      u_host.stop;
      `CHK("nack", 1'b0, a)
   endtask

   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
      t_reset;
      t_burst;
      t_modes;
      t_pages;
      end_of_test;
   end
endmodule
